//--- verilog/prog_mem_regs.svh
// Constants for the program memory table read block.
// Assumes inclusion by bare name from design files.
`ifndef PROG_MEM_REGS_SVH
`define PROG_MEM_REGS_SVH
`define PM_WORDS 4096
`define PM_ADDR_W 12
`define PM_DATA_W 16
`define PM_RESET_VECTOR 12'h000
`define PM_HIGH_USED 8
`define PM_TABLE_CYCLES 2
`define PM_PAGE_BITS 8
`endif

//--- verilog/prog_mem_pkg.sv
// Types shared by the program memory table read block.
// Assumes nothing beyond the constants header.
package prog_mem_pkg;
   typedef enum logic [1:0] {
      OP_NONE,
      OP_TABLE,
      OP_EXT_TABLE
   } table_op_e;
endpackage

//--- verilog/prog_mem_if.sv
// Interface joining the table read controller to the program store array.
// Assumes a single clock domain.
`timescale 1ns/1ps
interface prog_mem_if #(parameter int AW = 12, parameter int DW = 16);
   logic [AW-1:0] readAddr;
   logic [DW-1:0] readData;
   logic writeEn;
   logic [AW-1:0] writeAddr;
   logic [DW-1:0] writeData;
   modport ctrl (output readAddr, output writeEn, output writeAddr, output writeData,
      input readData);
   modport store (input readAddr, input writeEn, input writeAddr, input writeData,
      output readData);
endinterface

//--- verilog/prog_store.sv
// Flash program store array: one registered read port, one write port.
// Assumes writes come only from the programming path.
`timescale 1ns/1ps
module prog_store #(
   parameter int WORDS = 4096,
   parameter int AW = 12,
   parameter int DW = 16
) (
   // Clock
   input wire logic core_clk,
   // Array access
   prog_mem_if.store mem
);
   logic [DW-1:0] words [WORDS];
   logic [DW-1:0] readWord;

   // ==========================================
   // Storage
   always_ff @(posedge core_clk) begin
      if (mem.writeEn) begin
         words[mem.writeAddr] <= mem.writeData;
      end
      readWord <= words[mem.readAddr];
   end
   assign mem.readData = readWord;
endmodule

//--- verilog/program_memory_table_read.sv
// Program memory read path: instruction fetch and table reads.
// Assumes the core issues one request per instruction cycle on core_clk.
//
// Functional notes
// - Program store holds 4K words of 16 bits, fetched by program counter.
// - After reset fetching starts at address zero.
// - Table data readable anywhere, addressed by a pointer separate from PC.
// - Low and high pointer registers together form the table word address.
// - Table read writes low word byte to the operand data location.
// - Same read loads high byte into the table high latch.
// - Unimplemented high byte bits read as zero in the latch after a table read; software latch writes keep all 8 bits.
// - Standard read targets sector 0; extended read targets any sector.
// - Table instructions take two instruction cycles.
// - Table high latch is software writable and readable.
// - Programming moves serial data on one two-way pin with external clock; this block leaves progClockIn and progDataIn unused.
// - Debug pins keep programming role while shared functions are disabled.
// - Debug data pin is two-way; debug clock is an input. This block ties progDataOe to 0, so it never drives the data pin.
// - PC low byte writes jump within 256-word page with a dummy cycle.
`timescale 1ns/1ps
`include "prog_mem_regs.svh"
module program_memory_table_read import prog_mem_pkg::*; #(
   parameter int AW = `PM_ADDR_W,
   parameter int DW = `PM_DATA_W,
   parameter int WORDS = `PM_WORDS,
   parameter int HIGH_USED = `PM_HIGH_USED
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Instruction fetch
   input wire logic fetchAdvance,
   input wire logic jumpLoad,
   input wire logic [AW-1:0] jumpAddr,
   input wire logic pcLowWrite,
   input wire logic [7:0] pcLowData,
   output logic [AW-1:0] programCounter,
   output logic [7:0] pcLowByte,
   output logic [DW-1:0] instrWord,
   output logic dummyCycle,
   // Table pointer and latch access
   input wire logic tblLowWrite,
   input wire logic tblHighWrite,
   input wire logic latchWrite,
   input wire logic [7:0] writeData,
   output logic [7:0] tblLow,
   output logic [7:0] tblHigh,
   output logic [7:0] table_high_latch,
   // Table read request and result
   input wire logic tableReq,
   input wire logic extendedReq,
   input wire logic [8:0] destAddr,
   output logic tableBusy,
   output logic dataWrite,
   output logic [8:0] dataAddr,
   output logic [7:0] dataByte,
   // Programming and debug pins
   input wire logic debugMode,
   input wire logic progClockIn,
   input wire logic progDataIn,
   output logic progDataOut,
   output logic progDataOe,
   output logic sharedFuncDisable,
   // Programming word loader
   input wire logic progWordValid,
   input wire logic [AW-1:0] progWordAddr,
   input wire logic [DW-1:0] progWordData
);
   typedef enum logic [1:0] {IDLE, READ, FINISH} tbl_state_e;

   tbl_state_e state, next_state;
   table_op_e op, next_op;
   logic [AW-1:0] pc, next_pc;
   logic [7:0] ptrLow, next_ptrLow, ptrHigh, next_ptrHigh, latch, next_latch;
   logic [8:0] dest, next_dest;
   logic wrStrobe, next_wrStrobe;
   logic [7:0] lowOut, next_lowOut;
   logic dummy, next_dummy;
   logic [DW-1:0] instr, next_instr;
   logic [AW-1:0] tableAddr;

   prog_mem_if #(.AW(AW), .DW(DW)) mem ();

   prog_store #(.WORDS(WORDS), .AW(AW), .DW(DW)) store (
      .core_clk(core_clk),
      .mem(mem)
   );

   // High pointer keeps only the bits above the low byte
   function automatic logic [AW-1:0] form_addr(input logic [7:0] hi, input logic [7:0] lo);
      logic [15:0] full;
      full = {hi, lo};
      return full[AW-1:0];
   endfunction

   // Zeroes high byte bits with no storage behind them
   function automatic logic [7:0] high_byte(input logic [DW-1:0] w);
      logic [7:0] m;
      m = 8'hff >> (8 - HIGH_USED);
      return w[15:8] & m;
   endfunction

   assign tableAddr = form_addr(ptrHigh, ptrLow);

   // ==========================================
   // Array access
   always_comb begin
      mem.readAddr = (state == IDLE) ? pc : tableAddr;
      mem.writeEn = progWordValid;
      mem.writeAddr = progWordAddr;
      mem.writeData = progWordData;
   end

   // ==========================================
   // Next state
   always_comb begin
      next_state = state;
      next_op = op;
      next_pc = pc;
      next_ptrLow = ptrLow;
      next_ptrHigh = ptrHigh;
      next_latch = latch;
      next_dest = dest;
      next_wrStrobe = 1'b0;
      next_lowOut = lowOut;
      next_dummy = 1'b0;
      next_instr = instr;
      if (tblLowWrite) begin
         next_ptrLow = writeData;
      end
      if (tblHighWrite) begin
         next_ptrHigh = writeData;
      end
      if (latchWrite) begin
         next_latch = writeData;
      end
      unique case (state)
         IDLE: begin
            if (fetchAdvance) begin
               next_instr = mem.readData;
               next_pc = pc + 1'b1;
            end
            if (jumpLoad) begin
               next_pc = jumpAddr;
               next_dummy = 1'b1;
            end else if (pcLowWrite) begin
               next_pc = {pc[AW-1:`PM_PAGE_BITS], pcLowData};
               next_dummy = 1'b1;
            end
            if (tableReq) begin
               next_state = READ;
               next_op = extendedReq ? OP_EXT_TABLE : OP_TABLE;
               // Standard form reaches sector 0 only
               next_dest = extendedReq ? destAddr : {1'b0, destAddr[7:0]};
            end
         end
         READ: begin
            next_state = FINISH;
         end
         FINISH: begin
            next_lowOut = mem.readData[7:0];
            next_latch = high_byte(mem.readData);
            next_wrStrobe = 1'b1;
            next_op = OP_NONE;
            next_state = IDLE;
         end
      endcase
   end

   // ==========================================
   // Registers
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state <= IDLE;
         op <= OP_NONE;
         pc <= `PM_RESET_VECTOR;
         ptrLow <= 8'h00;
         ptrHigh <= 8'h00;
         latch <= 8'h00;
         dest <= 9'h000;
         wrStrobe <= 1'b0;
         lowOut <= 8'h00;
         dummy <= 1'b0;
         instr <= 16'h0000;
      end else begin
         state <= next_state;
         op <= next_op;
         pc <= next_pc;
         ptrLow <= next_ptrLow;
         ptrHigh <= next_ptrHigh;
         latch <= next_latch;
         dest <= next_dest;
         wrStrobe <= next_wrStrobe;
         lowOut <= next_lowOut;
         dummy <= next_dummy;
         instr <= next_instr;
      end
   end

   // ==========================================
   // Outputs
   assign programCounter = pc;
   assign pcLowByte = pc[7:0];
   assign instrWord = instr;
   assign dummyCycle = dummy;
   assign tblLow = ptrLow;
   assign tblHigh = ptrHigh;
   assign table_high_latch = latch;
   assign tableBusy = (state != IDLE);
   assign dataWrite = wrStrobe;
   assign dataAddr = dest;
   assign dataByte = lowOut;

   // Serial pin roles; protocol lives outside this block
   assign progDataOut = 1'b0;
   assign progDataOe = 1'b0;
   assign sharedFuncDisable = debugMode;
endmodule

//--- verif/prog_mem_properties.sv
// Checker of table read timing, results and program counter jumps.
// Assumes a bind onto program_memory_table_read.
`timescale 1ns/1ps
module prog_mem_properties #(parameter int HIGH_USED = 8) (
   // Clock, reset and requests
   input wire logic core_clk, reset, tableReq, extendedReq, latchWrite,
   input wire logic tblLowWrite, pcLowWrite, jumpLoad, debugMode,
   input wire logic [8:0] destAddr,
   input wire logic [7:0] writeData, pcLowData,
   // Results
   input wire logic tableBusy, dataWrite, dummyCycle, sharedFuncDisable,
   input wire logic [8:0] dataAddr,
   input wire logic [7:0] table_high_latch, tblLow,
   input wire logic [11:0] programCounter
);
   // =====
   // Destination expected for the read in flight
   logic [8:0] reqDest;
   logic [8:0] next_reqDest;
   always_comb begin
      next_reqDest = reqDest;
      if (tableReq && !tableBusy) next_reqDest = extendedReq ? destAddr : {1'b0, destAddr[7:0]};
   end
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) reqDest <= 9'h000;
      else reqDest <= next_reqDest;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   a_read_two_cycles:
      assert property (tableReq && !tableBusy |=> tableBusy ##1 tableBusy ##1
         (!tableBusy && dataWrite)) else $error("read timing");
   a_strobe_single:
      assert property (dataWrite |=> !dataWrite) else $error("strobe width");
   a_dest_sector:
      assert property (dataWrite |-> dataAddr == reqDest) else $error("dest");
   a_high_unused:
      assert property (dataWrite |-> (table_high_latch >> HIGH_USED) == 8'h00)
         else $error("unused high bits");
   a_pc_reset_zero:
      assert property ($past(reset) |-> programCounter == 12'h000) else $error("pc reset");
   a_page_jump:
      assert property (pcLowWrite && !jumpLoad && !tableBusy |=> programCounter ==
         {$past(programCounter[11:8]), $past(pcLowData)}) else $error("page jump");
   a_dummy_after_jump:
      assert property ((jumpLoad || pcLowWrite) && !tableBusy |=> dummyCycle)
         else $error("dummy cycle");
   a_latch_sw_write:
      assert property (latchWrite && !tableBusy |=> table_high_latch == $past(writeData))
         else $error("latch write");
   a_ptr_low_write:
      assert property (tblLowWrite && !tableBusy |=> tblLow == $past(writeData))
         else $error("pointer write");
   a_debug_share:
      assert property (sharedFuncDisable == debugMode) else $error("shared pins");
   c_ext_read: cover property (dataWrite && dataAddr[8]);
   c_page_jump: cover property (pcLowWrite && !tableBusy);
   c_latch_write: cover property (latchWrite && !tableBusy);
endmodule
bind program_memory_table_read prog_mem_properties #(.HIGH_USED(HIGH_USED)) i_props (.*);

//--- verif/data_sink.sv
// Data memory model that stores every table read low byte.
// Assumes single-cycle write strobes on core_clk.
`timescale 1ns/1ps
module data_sink (
   // Clock
   input wire logic core_clk,
   // Write port
   input wire logic dataWrite,
   input wire logic [8:0] dataAddr,
   input wire logic [7:0] dataByte
);
   // =====
   // Bit 8 of the address selects the sector
   logic [7:0] ram [512];
   always_ff @(posedge core_clk) begin
      if (dataWrite) ram[dataAddr] <= dataByte;
   end
endmodule

//--- verif/tb_program_memory_table_read.sv
// Bench for the table read path with a data memory model.
// Assumes design, package, interface and store compile first.
`timescale 1ns/1ps
module tb_program_memory_table_read;
   localparam int HU = 6;
   logic core_clk = 1'b0, reset = 1'b1, fetchAdvance = 1'b0, jumpLoad = 1'b0, pcLowWrite = 1'b0;
   logic tblLowWrite = 1'b0, tblHighWrite = 1'b0, latchWrite = 1'b0, tableReq = 1'b0;
   logic extendedReq = 1'b0, debugMode = 1'b0, progWordValid = 1'b0;
   logic progClockIn = 1'b0, progDataIn = 1'b0;
   logic [11:0] jumpAddr = 12'h000, progWordAddr = 12'h000, programCounter;
   logic [7:0] pcLowData = 8'h00, writeData = 8'h00, pcLowByte, tblLow, tblHigh;
   logic [7:0] table_high_latch, dataByte;
   logic [8:0] destAddr = 9'h000, dataAddr;
   logic [15:0] progWordData = 16'h0000, instrWord;
   logic dummyCycle, tableBusy, dataWrite, progDataOut, progDataOe, sharedFuncDisable;
   int err_count = 0, compares = 0, n;
   typedef struct packed {logic [7:0] hi; logic [7:0] lo; logic [15:0] w; logic ext;
      logic [8:0] dst;} row_s;
   // Upper pointer bits of row 2 must be ignored
   row_s rows [4] = '{'{8'h0f, 8'h06, 16'h001a, 1'b0, 9'h180},
      '{8'h0f, 8'h05, 16'hc30f, 1'b1, 9'h1a0}, '{8'h3f, 8'h07, 16'h7e55, 1'b0, 9'h081},
      '{8'h00, 8'h00, 16'hffaa, 1'b1, 9'h0ff}};
   program_memory_table_read #(.HIGH_USED(HU)) i_dut (.*);
   data_sink i_sink (.*);
   initial begin
      forever #25 core_clk = ~core_clk;
   end
   // =====
   // Shared tasks
   task automatic tick(input int k = 1);
      repeat (k) @(posedge core_clk);
      #2;
   endtask
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic tread(input logic [7:0] hi, lo, input logic ext, input logic [8:0] dst);
      writeData = lo;
      tblLowWrite = 1'b1;
      tick();
      tblLowWrite = 1'b0;
      writeData = hi;
      tblHighWrite = 1'b1;
      tick();
      tblHighWrite = 1'b0;
      tableReq = 1'b1;
      extendedReq = ext;
      destAddr = dst;
      tick();
      tableReq = 1'b0;
      n = 0;
      while (dataWrite !== 1'b1 && n < 8) begin
         tick();
         n++;
      end
      if (n == 8) begin
         err_count++;
         end_of_test();
      end
   endtask
   // =====
   // Main sequence
   initial begin
      tick(16);
      reset = 1'b0;
      check("pc", programCounter, 12'h000);
      check("oe", progDataOe, 1'b0);
      check("dout", progDataOut, 1'b0);
      foreach (rows[i]) begin
         progWordValid = 1'b1;
         progWordAddr = {rows[i].hi[3:0], rows[i].lo};
         progWordData = rows[i].w;
         tick();
      end
      progWordValid = 1'b0;
      foreach (rows[i]) begin
         tread(rows[i].hi, rows[i].lo, rows[i].ext, rows[i].dst);
         check("ptrHigh", tblHigh, rows[i].hi);
         check("byte", dataByte, rows[i].w[7:0]);
         check("latch", table_high_latch, rows[i].w[15:8] & (8'hff >> (8 - HU)));
         check("addr", dataAddr, rows[i].ext ? rows[i].dst : {1'b0, rows[i].dst[7:0]});
      end
      tick();
      check("sink", i_sink.ram[9'h1a0], 8'h0f);
      // Latch write kept clear of reads
      writeData = 8'h5c;
      latchWrite = 1'b1;
      tick();
      latchWrite = 1'b0;
      check("latch", table_high_latch, 8'h5c);
      tableReq = 1'b1;
      destAddr = 9'h0fe;
      tick(2);
      tableReq = 1'b0;
      check("busy", tableBusy, 1'b1);
      n = 0;
      repeat (6) begin
         if (dataWrite === 1'b1) n++;
         tick();
      end
      check("strobes", 16'(n), 16'h0001);
      check("sink", i_sink.ram[9'h0fe], 8'haa);
      jumpAddr = 12'h3a5;
      jumpLoad = 1'b1;
      tick();
      jumpLoad = 1'b0;
      check("pc", programCounter, 12'h3a5);
      check("dummy", dummyCycle, 1'b1);
      tick();
      pcLowData = 8'h10;
      pcLowWrite = 1'b1;
      tick();
      pcLowWrite = 1'b0;
      check("dummy", dummyCycle, 1'b1);
      check("pc", programCounter, 12'h310);
      check("pcLow", pcLowByte, 8'h10);
      debugMode = 1'b1;
      tick();
      check("shared", sharedFuncDisable, 1'b1);
      reset = 1'b1;
      tick();
      check("pc", programCounter, 12'h000);
      // Fetch at the first edge after release reads the word at address zero
      reset = 1'b0;
      fetchAdvance = 1'b1;
      tick();
      fetchAdvance = 1'b0;
      check("instr", instrWord, 16'hffaa);
      check("pc", programCounter, 12'h001);
      end_of_test();
   end
endmodule
